// ==== inc/sadcc_defines.svh ====
// Constants for the successive-approximation converter control block
`ifndef SADCC_DEFINES_SVH
`define SADCC_DEFINES_SVH

`define SADCC_SAMPLE_CYCLES  5'h04
`define SADCC_CONVERT_CYCLES 5'h0c
`define SADCC_TOTAL_CYCLES   5'h10
`define SADCC_RESULT_BITS    12
`define SADCC_FULL_SCALE     12'hfff
`define SADCC_LSB_DIVISOR    4096
`define SADCC_DIV_SEL_BITS   3
`define SADCC_SRC_SEL_BITS   4
`define SADCC_CHAN_SEL_BITS  3
`define SADCC_REF_SEL_BITS   2
`define SADCC_SRC_EXTERNAL   4'h0
`define SADCC_FMT_LEFT       1'h0

`endif

// ==== inc/sadcc_pkg.sv ====
// Types for the successive-approximation converter control block
package sadcc_pkg;

   typedef enum logic [2:0] {
      ST_OFF    = 3'h0,
      ST_IDLE   = 3'h1,
      ST_ARMED  = 3'h2,
      ST_SAMPLE = 3'h3,
      ST_CONV   = 3'h4,
      ST_LATCH  = 3'h5
   } sadcc_state_type;

endpackage : sadcc_pkg

// ==== design/sadcc_clkdiv.sv ====
// Power-of-two divider giving half-period enables of the converter clock
`timescale 1ns/1ps
`default_nettype none
`include "sadcc_defines.svh"

module sadcc_clkdiv #(
   parameter int SEL_W = `SADCC_DIV_SEL_BITS
) (
   input  wire logic             clk_i,
   input  wire logic             srst_i,
   input  wire logic             run_i,
   input  wire logic [SEL_W-1:0] sel_i,
   output logic                  half_o
);

   initial begin
      if (SEL_W < 1 || SEL_W > 5) begin
         $error("sadcc_clkdiv: unsupported select width");
      end
   end

   localparam int CW = (1 << SEL_W);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          half;
   } sadcc_div_type;

   sadcc_div_type s_q;
   sadcc_div_type s_d;
   logic [CW-1:0] lim;

   // ---------------------------------------------------------------
   // Divider
   // ---------------------------------------------------------------
   // A clock of period 2^sel system cycles has half periods of 2^(sel-1);
   // sel 0 uses a pulse each cycle, so one converter clock is two halves.
   always_comb begin
      lim = CW'(1) << sel_i;
      s_d = s_q;
      s_d.half = 1'b0;
      if (!run_i) begin
         s_d.cnt = '0;
      end else if (sel_i == '0 || s_q.cnt >= (lim >> 1) - CW'(1)) begin
         s_d.cnt  = '0;
         s_d.half = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt + CW'(1);
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign half_o = s_q.half;

endmodule : sadcc_clkdiv
`default_nettype wire

// ==== design/sadcc_top.sv ====
// Conversion sequencer of a 12-bit successive-approximation converter
//
// Overview of operation
// RL1 - Four clocks sampling then twelve converting, sixteen converter clocks in all.
// RL2 - Result written at end of conversion, latched half a clock later.
// RL3 - Start raised inside that half clock lets the result pair change.
// RL4 - Software should wait over half a clock before next start.
// RL5 - Software starts a conversion by driving start low, high, low.
// RL6 - Busy high during conversion, low at completion, result then valid.
// RL7 - Power enable must be set; no conversion while it is clear.
// RL8 - Converter clock derived from the three-bit divider select field.
// RL9 - Internal source selection disconnects the external channel input.
// RL10 - Software configures the pin for analog before choosing the channel.
// RL11 - Reference source chosen by the two-bit reference select field.
// RL12 - Result arrangement in the register pair set by format bit.
// RL13 - Interrupt delivered only when global and converter enables are high.
// RL14 - Polling software may leave the converter interrupt unconfigured.
// RL15 - Power enable clear switches converter circuits fully off.
// RL16 - Twelve-bit result; all ones equals the selected reference.
// RL17 - One code step is the reference divided by 4096.
// RL18 - Transitions half an LSB early; last one 1.5 LSB below reference.
// RL19 - Rising start resets converter and clears busy; busy set on start. Code ignores a rising start during sampling and conversion.
// RL20 - Completion sets the interrupt request flag and signals if enabled.
// RL21 - Sampling begins on the falling start edge after the rising one.
// RL22 - Converter clock is the system clock over a power of two.
`timescale 1ns/1ps
`default_nettype none
`include "sadcc_defines.svh"

module sadcc_top #(
   parameter int RES_W = `SADCC_RESULT_BITS,
   parameter int DIV_W = `SADCC_DIV_SEL_BITS
) (
   input  wire logic                         REF_CLK_I,
   input  wire logic                         SRST_I,
   input  wire logic                         START_I,
   input  wire logic                         CONVERTER_POWER_ENABLE_I,
   input  wire logic [DIV_W-1:0]             ADC_CLOCK_DIVIDER_SELECT_I,
   input  wire logic [`SADCC_SRC_SEL_BITS-1:0] INPUT_SOURCE_SELECT_I,
   input  wire logic [`SADCC_CHAN_SEL_BITS-1:0] EXTERNAL_CHANNEL_SELECT_I,
   input  wire logic [`SADCC_REF_SEL_BITS-1:0] REFERENCE_SOURCE_SELECT_I,
   input  wire logic                         RESULT_FORMAT_SELECT_I,
   input  wire logic                         GLOBAL_INTERRUPT_ENABLE_I,
   input  wire logic                         CONVERSION_INTERRUPT_ENABLE_I,
   input  wire logic                         INTERRUPT_FLAG_CLEAR_I,
   input  wire logic                         COMPARATOR_I,
   output logic                              ANALOG_POWER_ON_O,
   output logic                              SAMPLE_O,
   output logic                              EXTERNAL_CONNECT_O,
   output logic [`SADCC_CHAN_SEL_BITS-1:0]   CHANNEL_MUX_O,
   output logic [`SADCC_SRC_SEL_BITS-1:0]    SOURCE_MUX_O,
   output logic [`SADCC_REF_SEL_BITS-1:0]    REFERENCE_MUX_O,
   output logic [RES_W-1:0]                  DAC_CODE_O,
   output logic                              CONVERSION_BUSY_FLAG_O,
   output logic [7:0]                        RESULT_HIGH_BYTE_O,
   output logic [7:0]                        RESULT_LOW_BYTE_O,
   output logic                              CONVERSION_INTERRUPT_FLAG_O,
   output logic                              INTERRUPT_REQUEST_O
);

   initial begin
      if (RES_W != `SADCC_RESULT_BITS || DIV_W < 1 || DIV_W > 5) begin
         $error("sadcc_top: unsupported parameter values");
      end
   end

   typedef struct packed {
      logic [1:0]                       start_sync;
      logic                             start_prev;
      sadcc_pkg::sadcc_state_type       state;
      logic                             phase;
      logic [4:0]                       clk_cnt;
      logic [RES_W-1:0]                 sar;
      logic [RES_W-1:0]                 bit_mask;
      logic [RES_W-1:0]                 pair;
      logic                             power;
      logic                             sample;
      logic                             ext_conn;
      logic [`SADCC_CHAN_SEL_BITS-1:0]  chan;
      logic [`SADCC_SRC_SEL_BITS-1:0]   src;
      logic [`SADCC_REF_SEL_BITS-1:0]   refsel;
      logic [RES_W-1:0]                 dac;
      logic                             busy;
      logic [7:0]                       res_hi;
      logic [7:0]                       res_lo;
      logic                             flag;
      logic                             irq;
   } sadcc_core_type;

   sadcc_core_type s_q;
   sadcc_core_type s_d;
   logic           half_tick;
   logic           div_run;
   logic [1:0]     cmp_sync_q;
   logic           start_rise;
   logic           start_fall;
   logic           adclk_edge;
   logic [15:0]    fmt_word;

   // ---------------------------------------------------------------
   // Clock divider
   // ---------------------------------------------------------------
   assign div_run = (s_q.state == sadcc_pkg::ST_SAMPLE) ||
                    (s_q.state == sadcc_pkg::ST_CONV)   ||
                    (s_q.state == sadcc_pkg::ST_LATCH);

   // RL8 RL22 divided converter clock
   sadcc_clkdiv #(
      .SEL_W (DIV_W)
   ) u_div (
      .clk_i  (REF_CLK_I),
      .srst_i (SRST_I),
      .run_i  (div_run),
      .sel_i  (ADC_CLOCK_DIVIDER_SELECT_I),
      .half_o (half_tick)
   );

   // Comparator is analog, so it is synchronised like a pin.
   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         cmp_sync_q <= '0;
      end else begin
         cmp_sync_q <= {cmp_sync_q[0], COMPARATOR_I};
      end
   end

   assign start_rise = s_q.start_sync[1] & ~s_q.start_prev;
   assign start_fall = ~s_q.start_sync[1] & s_q.start_prev;
   // Rising converter clock edge is the second half period
   assign adclk_edge = half_tick & s_q.phase;

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.start_sync = {s_q.start_sync[0], START_I};
      s_d.start_prev = s_q.start_sync[1];
      if (half_tick) begin
         s_d.phase = ~s_q.phase;
      end
      // RL15 analog off while disabled
      s_d.power = CONVERTER_POWER_ENABLE_I;
      // RL9 internal source disconnects pins
      s_d.ext_conn = (INPUT_SOURCE_SELECT_I == `SADCC_SRC_EXTERNAL) &&
                     CONVERTER_POWER_ENABLE_I;
      s_d.chan = EXTERNAL_CHANNEL_SELECT_I;
      s_d.src  = INPUT_SOURCE_SELECT_I;
      // RL11 reference mux select
      s_d.refsel = REFERENCE_SOURCE_SELECT_I;
      // RL12 result arrangement
      if (RESULT_FORMAT_SELECT_I == `SADCC_FMT_LEFT) begin
         fmt_word = {s_q.pair, 4'h0};
      end else begin
         fmt_word = {4'h0, s_q.pair};
      end
      s_d.res_hi = fmt_word[15:8];
      s_d.res_lo = fmt_word[7:0];
      // Set beats clear so a completion is never lost
      if (INTERRUPT_FLAG_CLEAR_I) begin
         s_d.flag = 1'b0;
      end

      unique case (s_q.state)
         sadcc_pkg::ST_OFF: begin
            s_d.busy = 1'b0;
            s_d.sample = 1'b0;
            if (CONVERTER_POWER_ENABLE_I) begin
               s_d.state = sadcc_pkg::ST_IDLE;
            end
         end
         sadcc_pkg::ST_IDLE: begin
            // RL19 rising start resets
            if (start_rise) begin
               s_d.busy  = 1'b0;
               s_d.state = sadcc_pkg::ST_ARMED;
            end
         end
         sadcc_pkg::ST_ARMED: begin
            // RL21 RL5 falling start begins sampling
            if (start_fall) begin
               s_d.busy    = 1'b1;
               s_d.sample  = 1'b1;
               s_d.phase   = 1'b0;
               s_d.clk_cnt = '0;
               s_d.sar     = '0;
               s_d.bit_mask = {1'b1, {(RES_W-1){1'b0}}};
               s_d.state   = sadcc_pkg::ST_SAMPLE;
            end
         end
         sadcc_pkg::ST_SAMPLE: begin
            // RL1 four sampling clocks
            if (adclk_edge) begin
               if (s_q.clk_cnt == `SADCC_SAMPLE_CYCLES - 5'h01) begin
                  s_d.sample  = 1'b0;
                  s_d.clk_cnt = '0;
                  s_d.dac     = s_q.bit_mask;
                  s_d.state   = sadcc_pkg::ST_CONV;
               end else begin
                  s_d.clk_cnt = s_q.clk_cnt + 5'h01;
               end
            end
         end
         sadcc_pkg::ST_CONV: begin
            // RL1 twelve bit trials, RL16 RL17 binary weights
            if (adclk_edge) begin
               if (cmp_sync_q[1]) begin
                  s_d.sar = s_q.sar | s_q.bit_mask;
               end
               s_d.bit_mask = s_q.bit_mask >> 1;
               s_d.dac = (cmp_sync_q[1] ? (s_q.sar | s_q.bit_mask) : s_q.sar)
                         | (s_q.bit_mask >> 1);
               s_d.clk_cnt = s_q.clk_cnt + 5'h01;
               if (s_q.clk_cnt == `SADCC_CONVERT_CYCLES - 5'h01) begin
                  // RL2 RL6 write pair, busy low
                  s_d.pair  = cmp_sync_q[1] ? (s_q.sar | s_q.bit_mask)
                                            : s_q.sar;
                  s_d.busy  = 1'b0;
                  // RL20 request flag on completion
                  s_d.flag  = 1'b1;
                  s_d.state = sadcc_pkg::ST_LATCH;
               end
            end
         end
         sadcc_pkg::ST_LATCH: begin
            // RL3 early start leaves the pair open to change
            if (start_rise) begin
               s_d.pair  = '0;
               s_d.state = sadcc_pkg::ST_ARMED;
            end else if (half_tick) begin
               // RL2 latched after half a clock
               s_d.state = sadcc_pkg::ST_IDLE;
            end
         end
         default: begin
            s_d.state = sadcc_pkg::ST_OFF;
         end
      endcase

      // RL7 no conversion without power
      if (!CONVERTER_POWER_ENABLE_I) begin
         s_d.state  = sadcc_pkg::ST_OFF;
         s_d.busy   = 1'b0;
         s_d.sample = 1'b0;
         s_d.dac    = '0;
      end
      // RL13 both enables gate the request
      s_d.irq = s_d.flag & GLOBAL_INTERRUPT_ENABLE_I &
                CONVERSION_INTERRUPT_ENABLE_I;
   end

   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // RL18 half-LSB offset lives in the analog DAC trim, not here
   assign ANALOG_POWER_ON_O           = s_q.power;
   assign SAMPLE_O                    = s_q.sample;
   assign EXTERNAL_CONNECT_O          = s_q.ext_conn;
   assign CHANNEL_MUX_O               = s_q.chan;
   assign SOURCE_MUX_O                = s_q.src;
   assign REFERENCE_MUX_O             = s_q.refsel;
   assign DAC_CODE_O                  = s_q.dac;
   assign CONVERSION_BUSY_FLAG_O      = s_q.busy;
   assign RESULT_HIGH_BYTE_O          = s_q.res_hi;
   assign RESULT_LOW_BYTE_O           = s_q.res_lo;
   assign CONVERSION_INTERRUPT_FLAG_O = s_q.flag;
   assign INTERRUPT_REQUEST_O         = s_q.irq;

endmodule : sadcc_top
`default_nettype wire

// ==== verif/sadcc_top_sva.sv ====
// Assertion checker for the converter control top ports
`timescale 1ns/1ps
`default_nettype none
`include "sadcc_defines.svh"

module sadcc_top_sva #(
   parameter int RES_W = `SADCC_RESULT_BITS,
   parameter int DIV_W = `SADCC_DIV_SEL_BITS
) (
   input wire logic             REF_CLK_I,
   input wire logic             SRST_I,
   input wire logic             CONVERTER_POWER_ENABLE_I,
   input wire logic [DIV_W-1:0] ADC_CLOCK_DIVIDER_SELECT_I,
   input wire logic [3:0]       INPUT_SOURCE_SELECT_I,
   input wire logic [1:0]       REFERENCE_SOURCE_SELECT_I,
   input wire logic             GLOBAL_INTERRUPT_ENABLE_I,
   input wire logic             CONVERSION_INTERRUPT_ENABLE_I,
   input wire logic             SAMPLE_O,
   input wire logic             EXTERNAL_CONNECT_O,
   input wire logic [1:0]       REFERENCE_MUX_O,
   input wire logic [RES_W-1:0] DAC_CODE_O,
   input wire logic             CONVERSION_BUSY_FLAG_O,
   input wire logic             CONVERSION_INTERRUPT_FLAG_O,
   input wire logic             INTERRUPT_REQUEST_O
);
   // ---------------------
   // Run lengths
   // ---------------------
   logic [15:0] bcnt_q;
   logic [15:0] scnt_q;
   logic [15:0] clen;
   logic [15:0] slen;
   assign clen = 16'h0010 << ADC_CLOCK_DIVIDER_SELECT_I;
   assign slen = 16'h0004 << ADC_CLOCK_DIVIDER_SELECT_I;
   // No reset needed: busy and sample are low while in reset
   always_ff @(posedge REF_CLK_I) begin
      bcnt_q <= CONVERSION_BUSY_FLAG_O ? bcnt_q + 16'h0001 : 16'h0000;
      scnt_q <= SAMPLE_O ? scnt_q + 16'h0001 : 16'h0000;
   end

   // ---------------------
   // Properties
   // ---------------------
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (SRST_I);

   sequence conv_end;
      $fell(CONVERSION_BUSY_FLAG_O) ##0 CONVERTER_POWER_ENABLE_I
         ##0 $past(CONVERTER_POWER_ENABLE_I);
   endsequence
   sequence samp_end;
      $fell(SAMPLE_O) ##0 CONVERSION_BUSY_FLAG_O;
   endsequence

   conv_len_a: assert property (conv_end |->
      bcnt_q + 16'h0001 >= clen && bcnt_q <= clen + 16'h0002)
      else $error("conversion length off");
   samp_len_a: assert property (samp_end |->
      scnt_q + 16'h0001 >= slen && scnt_q <= slen + 16'h0002)
      else $error("sampling length off");
   samp_start_a: assert property ($rose(CONVERSION_BUSY_FLAG_O) |-> SAMPLE_O)
      else $error("busy rose without sampling");
   dac_mid_a: assert property (samp_end |->
      DAC_CODE_O == {1'b1, {(RES_W-1){1'b0}}})
      else $error("first trial code wrong");
   flag_set_a: assert property (conv_end |-> CONVERSION_INTERRUPT_FLAG_O)
      else $error("flag not set at completion");
   // Request follows the flag in the same cycle, enables one cycle behind
   irq_gate_a: assert property (!SRST_I |=> INTERRUPT_REQUEST_O ==
      (CONVERSION_INTERRUPT_FLAG_O && $past(GLOBAL_INTERRUPT_ENABLE_I
      && CONVERSION_INTERRUPT_ENABLE_I)))
      else $error("interrupt request gating wrong");
   ext_disc_a: assert property (!SRST_I |=> EXTERNAL_CONNECT_O ==
      $past(INPUT_SOURCE_SELECT_I == 4'h0 && CONVERTER_POWER_ENABLE_I))
      else $error("external input connect wrong");
   ref_sel_a: assert property (!SRST_I |=>
      REFERENCE_MUX_O == $past(REFERENCE_SOURCE_SELECT_I))
      else $error("reference select not followed");
   power_off_a: assert property (!CONVERTER_POWER_ENABLE_I [*2] |->
      !CONVERSION_BUSY_FLAG_O && !SAMPLE_O)
      else $error("converter active while unpowered");
endmodule : sadcc_top_sva

bind sadcc_top sadcc_top_sva #(.RES_W(RES_W), .DIV_W(DIV_W)) u_sva (
   .REF_CLK_I(REF_CLK_I), .SRST_I(SRST_I),
   .CONVERTER_POWER_ENABLE_I(CONVERTER_POWER_ENABLE_I),
   .ADC_CLOCK_DIVIDER_SELECT_I(ADC_CLOCK_DIVIDER_SELECT_I),
   .INPUT_SOURCE_SELECT_I(INPUT_SOURCE_SELECT_I),
   .REFERENCE_SOURCE_SELECT_I(REFERENCE_SOURCE_SELECT_I),
   .GLOBAL_INTERRUPT_ENABLE_I(GLOBAL_INTERRUPT_ENABLE_I),
   .CONVERSION_INTERRUPT_ENABLE_I(CONVERSION_INTERRUPT_ENABLE_I),
   .SAMPLE_O(SAMPLE_O), .EXTERNAL_CONNECT_O(EXTERNAL_CONNECT_O),
   .REFERENCE_MUX_O(REFERENCE_MUX_O), .DAC_CODE_O(DAC_CODE_O),
   .CONVERSION_BUSY_FLAG_O(CONVERSION_BUSY_FLAG_O),
   .CONVERSION_INTERRUPT_FLAG_O(CONVERSION_INTERRUPT_FLAG_O),
   .INTERRUPT_REQUEST_O(INTERRUPT_REQUEST_O)
);
`default_nettype wire

// ==== verif/testbench.sv ====
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none

module testbench;
   logic        clk = 1'b0, rst = 1'b1, st = 1'b0, pwr = 1'b0;
   logic        fmt = 1'b0, gie = 1'b0, cie = 1'b0, fclr = 1'b0;
   logic        cmp = 1'b0;
   logic [2:0]  sel = 3'h4, ch = 3'h0;
   logic [3:0]  src = 4'h0;
   logic [1:0]  rs = 2'h0;
   logic [11:0] vin = 12'h000, dac;
   logic        busy, flg, irq, pon, ext;
   logic [2:0]  chm;
   logic [3:0]  srcm;
   logic [7:0]  hi, lo;
   logic [16:0] exp_q[$];
   int          num_errors = 0, num_checks = 0;

   sadcc_top u_sadcc_top (
      .REF_CLK_I(clk), .SRST_I(rst), .START_I(st),
      .CONVERTER_POWER_ENABLE_I(pwr), .ADC_CLOCK_DIVIDER_SELECT_I(sel),
      .INPUT_SOURCE_SELECT_I(src), .EXTERNAL_CHANNEL_SELECT_I(ch),
      .REFERENCE_SOURCE_SELECT_I(rs), .RESULT_FORMAT_SELECT_I(fmt),
      .GLOBAL_INTERRUPT_ENABLE_I(gie), .CONVERSION_INTERRUPT_ENABLE_I(cie),
      .INTERRUPT_FLAG_CLEAR_I(fclr), .COMPARATOR_I(cmp),
      .ANALOG_POWER_ON_O(pon), .SAMPLE_O(), .EXTERNAL_CONNECT_O(ext),
      .CHANNEL_MUX_O(chm), .SOURCE_MUX_O(srcm), .REFERENCE_MUX_O(),
      .DAC_CODE_O(dac), .CONVERSION_BUSY_FLAG_O(busy),
      .RESULT_HIGH_BYTE_O(hi), .RESULT_LOW_BYTE_O(lo),
      .CONVERSION_INTERRUPT_FLAG_O(flg), .INTERRUPT_REQUEST_O(irq)
   );

   always #5 clk = ~clk;
   always @(posedge clk) #1 cmp = (vin >= dac);

   // ---------------------
   // Tasks
   // ---------------------
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   task automatic chk(input string n, input logic [11:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", n, exp, got);
      end
   endtask : chk

   task automatic wait_busy(input logic v);
      for (int i = 0; i < 3000 && busy !== v; i++) tick(1);
      chk("busy", busy, v);
   endtask : wait_busy

   task automatic complete_run();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : complete_run

   // Start pulse low-high-low; early restarts inside the latch window
   task automatic conv(input logic early);
      fclr = 1'b1;
      tick(1);
      fclr = 1'b0;
      tick(1);
      chk("flag_clear", flg, 1'b0);
      exp_q.push_back({fmt ? {4'h0, vin} : {vin, 4'h0}, gie & cie});
      st = 1'b1;
      tick(6);
      st = 1'b0;
      wait_busy(1'b1);
      chk("power_on", pon, 1'b1);
      chk("channel", chm, ch);
      chk("source", srcm, src);
      chk("ext_connect", ext, src == 4'h0);
      wait_busy(1'b0);
      if (early) st = 1'b1;
      tick(40);
      if (early) begin
         chk("early_high", hi, 8'h00);
         chk("early_low", lo, 8'h00);
      end
   endtask : conv

   // ---------------------
   // Result monitor
   // ---------------------
   initial forever begin
      logic [16:0] e;
      @(negedge busy iff (!rst && pwr));
      tick(2);
      if (exp_q.size() > 0) begin
         e = exp_q.pop_front();
         chk("result_high", hi, e[16:9]);
         chk("result_low", lo, e[8:1]);
         chk("irq", irq, e[0]);
         chk("flag", flg, 1'b1);
      end else begin
         chk("result_note", 12'h000, 12'h001);
      end
   end

   // ---------------------
   // Main sequence
   // ---------------------
   initial begin
      void'($urandom(32'h71bf));
      tick(3);
      rst = 1'b0;
      st = 1'b1;
      tick(6);
      st = 1'b0;
      tick(30);
      chk("busy_off", busy, 1'b0);
      pwr = 1'b1;
      tick(4);
      for (int i = 0; i < 12; i++) begin
         sel = 3'h4 + 3'($urandom % 3);
         src = i[0] ? 4'($urandom % 15 + 1) : 4'h0;
         ch = 3'($urandom);
         rs = 2'(i);
         fmt = i[2];
         {gie, cie} = 2'(i);
         vin = (i == 0) ? 12'hfff : (i == 1) ? 12'h000 : 12'($urandom);
         tick(2);
         conv(i == 11);
      end
      // Power drop aborts a running conversion
      st = 1'b0;
      wait_busy(1'b1);
      tick(50);
      pwr = 1'b0;
      tick(2);
      chk("busy_abort", busy, 1'b0);
      chk("power_off", pon, 1'b0);
      tick(20);
      chk("busy_off", busy, 1'b0);
      chk("notes_left", 12'(exp_q.size()), 12'h000);
      complete_run();
   end

   // Cut a hang well after the expected run time
   initial begin
      #500000;
      num_errors++;
      complete_run();
   end
endmodule : testbench
`default_nettype wire
